// >>> design/sbcse_encoder.sv
// spi command interpreter and status encoder of a system basis chip
// assumes spi pins synchronous to CLK_I and sclk at most clk/4
//
// Overview of operation
// RULE1: threshold code 01/10/11 selects level one/two/three; 00 keeps previous.
// RULE2: thirty-two watchdog periods come from a 5-bit field.
// RULE3: period (n+1)*16 ms below 16, else n*48-464 ms.
// RULE4: restart cause 2-bit code: none, undervoltage, watchdog/cyclic wake, flash/external.
// RULE5: read-only access of diagnosis register clears restart cause.
// RULE6: leaving sleep or fail-safe clears restart cause.
// RULE7: limp-home cause 3-bit code, 111 reserved.
// RULE8: switching limp-home output off over spi returns cause to 000.
// RULE9: 3-bit hardware configuration read-out, codes 000 to 011.
// RULE10: top read-out bit set means software development mode, no watchdog reaction.
// RULE11: non read-only frames return data asked by previous command.
// RULE12: first frame after sleep or fail-safe reports that mode and register.
// RULE13: first frame after failure restart reports restart and limp-home register.
// RULE14: first frame after requested restart or init carries main configuration.
// RULE15: automatic first frame does not clear diagnostic bits.
// RULE16: read-only clears selected interrupt bits, live state bits unaffected.
// RULE17: read-only writes no register and leaves mode unchanged.
// RULE18: read-only counts as watchdog service.
// RULE19: read-only returns selected register within the same frame.
// RULE20: frames move least significant bit first.
// RULE21: select 100 main, 101 comm, 110 watchdog, 111 diagnosis; 111 not writable.
// RULE22: command applied only when chip select rises after a full frame.
`timescale 1ns/10ps
`default_nettype none
`include "sbcse_defines.svh"

module sbcse_encoder (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic SCLK_I,
  input wire logic SDI_I,
  output logic SERIAL_DATA_OUT_O,
  output logic SERIAL_DATA_OUT_OE_O,
  input wire logic [2:0] CUR_MODE_I,
  input wire logic NORMAL_ENTRY_I,
  input wire sbcse_pkg::sbcse_entry_type ENTRY_FROM_I,
  input wire logic LEAVE_SLEEP_FS_I,
  input wire logic RESTART_EVENT_I,
  input wire logic [1:0] RESTART_CAUSE_I,
  input wire logic LIMP_EVENT_I,
  input wire logic [2:0] LIMP_CAUSE_I,
  input wire logic [9:0] WAKE_SET_I,
  input wire logic [2:0] HW_CONFIG_I,
  output logic [1:0] RESET_THRESHOLD_O,
  output logic [4:0] WD_FIELD_O,
  output logic [10:0] WD_PERIOD_MS_O,
  output logic SW_DEV_MODE_O,
  output logic WD_SERVICE_O,
  output logic MODE_REQ_VALID_O,
  output logic [2:0] MODE_REQ_O,
  output logic [9:0] MAIN_REG_O,
  output logic [9:0] COMM_REG_O,
  output logic [9:0] WDOG_REG_O,
  output logic [1:0] RESTART_CAUSE_O,
  output logic [2:0] LIMP_CAUSE_O
);

  sbcse_pkg::sbcse_state_type st;
  sbcse_pkg::sbcse_state_type next_st;
  sbcse_pkg::sbcse_frame_type rx;
  sbcse_pkg::sbcse_frame_type reply;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic [2:0] ro_mode;
  logic [2:0] ro_sel;
  logic [9:0] diag_word;

  assign cs_fall = st.cs_q & ~CHIP_SELECT_N_I;
  assign cs_rise = ~st.cs_q & CHIP_SELECT_N_I;
  assign sclk_rise = ~CHIP_SELECT_N_I & ~st.sclk_q & SCLK_I;
  assign sclk_fall = ~CHIP_SELECT_N_I & st.sclk_q & ~SCLK_I;
  assign frame_done = cs_rise & (st.cnt == `SBCSE_FRAME_BITS); // RULE22
  assign rx = st.in_sh;

  // header of the frame in flight, valid once the sixth bit arrives
  assign ro_mode = st.in_sh[13:11];
  assign ro_sel = {SDI_I, st.in_sh[15:14]};

  // live hardware configuration sits beside the sticky causes
  assign diag_word = {2'h0, HW_CONFIG_I, st.limp, st.restart}; // RULE4 RULE7 RULE9

  function automatic logic [9:0] sel_data(input logic [2:0] sel,
                                          input sbcse_pkg::sbcse_state_type s,
                                          input logic [9:0] diag);
    logic [9:0] d;
    d = 10'h000;
    if (sel == `SBCSE_SEL_MAIN) begin // RULE21
      d = {s.main_reg[9:2], s.thr};
    end else if (sel == `SBCSE_SEL_COMM) begin
      d = s.comm_reg;
    end else if (sel == `SBCSE_SEL_WDOG) begin
      d = s.wdog_reg;
    end else if (sel == `SBCSE_SEL_DIAG) begin
      d = diag;
    end else if (sel == `SBCSE_SEL_WAKE) begin
      d = s.wake_int;
    end
    return d;
  endfunction : sel_data

  // reply loaded when chip select falls
  always_comb begin
    reply.mode = CUR_MODE_I;
    reply.sel = st.last_sel; // RULE11
    if (st.first_pend) begin
      reply.mode = st.first_mode; // RULE12 RULE13 RULE14
      reply.sel = st.first_sel;
    end
    reply.data = sel_data(reply.sel, st, diag_word);
  end

  always_comb begin
    next_st = st;
    next_st.cs_q = CHIP_SELECT_N_I;
    next_st.sclk_q = SCLK_I;
    next_st.wd_svc = 1'b0;
    next_st.mode_req_v = 1'b0;

    // serial shifting
    if (cs_fall) begin
      next_st.cnt = `SBCSE_CNT_ZERO;
      next_st.out_sh = reply;
      next_st.first_pend = 1'b0; // RULE15
    end else if (sclk_rise && st.cnt != `SBCSE_FRAME_BITS) begin
      next_st.in_sh = {SDI_I, st.in_sh[15:1]}; // RULE20
      next_st.cnt = st.cnt + `SBCSE_CNT_ONE;
      if (st.cnt == `SBCSE_HDR_LAST && ro_mode == `SBCSE_MODE_READ_ONLY) begin
        // five header bits already left, the sixth still drives sdo; only the data field can follow
        next_st.out_sh[10:1] = sel_data(ro_sel, st, diag_word); // RULE19
      end
    end else if (sclk_fall) begin
      next_st.out_sh = {1'b0, st.out_sh[15:1]}; // RULE20
    end

    // command completion
    if (frame_done) begin
      next_st.wd_svc = 1'b1; // RULE18
      if (rx.mode == `SBCSE_MODE_READ_ONLY) begin
        // no write and no mode request for a read-only frame
        if (rx.sel == `SBCSE_SEL_DIAG) begin // RULE16 RULE17
          next_st.restart = 2'h0; // RULE5
        end else if (rx.sel == `SBCSE_SEL_WAKE) begin
          next_st.wake_int = 10'h000; // RULE16
        end
      end else begin
        next_st.last_sel = rx.sel; // RULE11
        next_st.mode_req_v = 1'b1;
        next_st.mode_req = rx.mode;
        if (rx.sel == `SBCSE_SEL_MAIN) begin
          next_st.main_reg = rx.data;
          if (rx.data[1:0] != `SBCSE_THR_HOLD) begin
            next_st.thr = rx.data[1:0]; // RULE1
          end
          if (!rx.data[`SBCSE_LH_BIT]) begin
            next_st.limp = 3'h0; // RULE8
          end
        end else if (rx.sel == `SBCSE_SEL_COMM) begin
          next_st.comm_reg = rx.data;
        end else if (rx.sel == `SBCSE_SEL_WDOG) begin
          next_st.wdog_reg = rx.data; // RULE2
        end
        // select 111 and unused codes write nothing (RULE21)
      end
    end

    // leaving sleep or fail-safe wipes the restart cause
    if (LEAVE_SLEEP_FS_I) begin
      next_st.restart = 2'h0; // RULE6
    end

    // hardware events win over any clear in the same cycle
    if (RESTART_EVENT_I) begin
      next_st.restart = RESTART_CAUSE_I; // RULE4
    end
    if (LIMP_EVENT_I) begin
      next_st.limp = LIMP_CAUSE_I; // RULE7
    end
    next_st.wake_int = next_st.wake_int | WAKE_SET_I;

    // first frame after entering normal mode
    if (NORMAL_ENTRY_I) begin
      next_st.first_pend = 1'b1;
      case (ENTRY_FROM_I)
        sbcse_pkg::SBCSE_FROM_SLEEP: begin
          next_st.first_mode = `SBCSE_MODE_SLEEP; // RULE12
          next_st.first_sel = `SBCSE_SEL_WAKE;
        end
        sbcse_pkg::SBCSE_FROM_FAILSAFE: begin
          next_st.first_mode = `SBCSE_MODE_FAILSAFE; // RULE12
          next_st.first_sel = `SBCSE_SEL_DIAG;
        end
        sbcse_pkg::SBCSE_FROM_RESTART_FAIL: begin
          next_st.first_mode = `SBCSE_MODE_RESTART; // RULE13
          next_st.first_sel = `SBCSE_SEL_DIAG;
        end
        sbcse_pkg::SBCSE_FROM_RESTART_REQ: begin
          next_st.first_mode = `SBCSE_MODE_RESTART; // RULE14
          next_st.first_sel = `SBCSE_SEL_MAIN;
        end
        default: begin
          next_st.first_mode = `SBCSE_MODE_INIT; // RULE14
          next_st.first_sel = `SBCSE_SEL_MAIN;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= '0;
      st.thr <= `SBCSE_THR_RESET;
      st.main_reg <= `SBCSE_MAIN_RESET;
      st.comm_reg <= `SBCSE_COMM_RESET;
      st.wdog_reg <= `SBCSE_WDOG_RESET;
      st.cs_q <= 1'b1;
      st.last_sel <= `SBCSE_SEL_MAIN;
      st.first_mode <= `SBCSE_MODE_INIT;
      st.first_sel <= `SBCSE_SEL_MAIN;
      st.mode_req <= `SBCSE_MODE_INIT;
    end else begin
      st <= next_st;
    end
  end

  sbcse_period u_period (
    .field_i(st.wdog_reg[4:0]),
    .period_ms_o(WD_PERIOD_MS_O)
  );

  // sdo is released while chip select is high
  assign SERIAL_DATA_OUT_O = st.out_sh[0];
  assign SERIAL_DATA_OUT_OE_O = ~CHIP_SELECT_N_I;
  assign RESET_THRESHOLD_O = st.thr;
  assign WD_FIELD_O = st.wdog_reg[4:0];
  assign SW_DEV_MODE_O = HW_CONFIG_I[2]; // RULE10
  assign WD_SERVICE_O = st.wd_svc;
  assign MODE_REQ_VALID_O = st.mode_req_v;
  assign MODE_REQ_O = st.mode_req;
  assign MAIN_REG_O = {st.main_reg[9:2], st.thr};
  assign COMM_REG_O = st.comm_reg;
  assign WDOG_REG_O = st.wdog_reg;
  assign RESTART_CAUSE_O = st.restart;
  assign LIMP_CAUSE_O = st.limp;

endmodule : sbcse_encoder
`default_nettype wire

// >>> design/sbcse_defines.svh
// constants of the spi status encoder: frame layout, codes, reset values
// assumes a 16-bit lsb-first frame clocked by the controller
`ifndef SBCSE_DEFINES_SVH
`define SBCSE_DEFINES_SVH

`define SBCSE_FRAME_BITS 5'h10
`define SBCSE_HDR_BITS 5'h06
`define SBCSE_HDR_LAST 5'h05
`define SBCSE_CNT_ZERO 5'h00
`define SBCSE_CNT_ONE 5'h01

// mode selection codes (bits 2..0 of a frame)
`define SBCSE_MODE_INIT 3'h0
`define SBCSE_MODE_NORMAL 3'h1
`define SBCSE_MODE_SLEEP 3'h2
`define SBCSE_MODE_RESTART 3'h3
`define SBCSE_MODE_FAILSAFE 3'h4
`define SBCSE_MODE_FLASH 3'h5
`define SBCSE_MODE_READ_ONLY 3'h7

// configuration select codes (bits 5..3 of a frame)
`define SBCSE_SEL_WAKE 3'h3
`define SBCSE_SEL_MAIN 3'h4
`define SBCSE_SEL_COMM 3'h5
`define SBCSE_SEL_WDOG 3'h6
`define SBCSE_SEL_DIAG 3'h7

// reset values of the writable registers, threshold hold code and limp-home bit index
`define SBCSE_MAIN_RESET 10'h115
`define SBCSE_COMM_RESET 10'h001
`define SBCSE_WDOG_RESET 10'h1EF
`define SBCSE_THR_RESET 2'h1
`define SBCSE_THR_HOLD 2'h0
`define SBCSE_LH_BIT 6

// watchdog period arithmetic, in ms
`define SBCSE_WD_STEP_LO 11'h010
`define SBCSE_WD_STEP_HI 11'h030
`define SBCSE_WD_OFFSET_HI 11'h1D0
`define SBCSE_WD_SPLIT 5'h10

`endif

// >>> design/sbcse_pkg.sv
// types of the spi status encoder
// assumes sbcse_defines.svh holds the numeric constants
package sbcse_pkg;

  // mode from which normal mode was entered
  typedef enum logic [2:0] {
    SBCSE_FROM_SLEEP,
    SBCSE_FROM_FAILSAFE,
    SBCSE_FROM_RESTART_FAIL,
    SBCSE_FROM_RESTART_REQ,
    SBCSE_FROM_INIT
  } sbcse_entry_type;

  typedef struct packed {
    logic [9:0] data;
    logic [2:0] sel;
    logic [2:0] mode;
  } sbcse_frame_type;

  typedef struct packed {
    logic [1:0] thr;
    logic [9:0] main_reg;
    logic [9:0] comm_reg;
    logic [9:0] wdog_reg;
    logic [9:0] wake_int;
    logic [1:0] restart;
    logic [2:0] limp;
    logic [15:0] in_sh;
    logic [15:0] out_sh;
    logic [4:0] cnt;
    logic cs_q;
    logic sclk_q;
    logic [2:0] last_sel;
    logic first_pend;
    logic [2:0] first_mode;
    logic [2:0] first_sel;
    logic wd_svc;
    logic mode_req_v;
    logic [2:0] mode_req;
  } sbcse_state_type;

endpackage : sbcse_pkg

// >>> design/sbcse_period.sv
// watchdog period decoder: 5-bit field to a period in ms
// assumes a purely combinational use by the encoder
`timescale 1ns/10ps
`default_nettype none
`include "sbcse_defines.svh"

module sbcse_period (
  input wire logic [4:0] field_i,
  output logic [10:0] period_ms_o
);

  logic [10:0] n;

  assign n = {6'h00, field_i};

  always_comb begin
    if (field_i < `SBCSE_WD_SPLIT) begin
      period_ms_o = (n + 11'h001) * `SBCSE_WD_STEP_LO; // RULE3
    end else begin
      period_ms_o = n * `SBCSE_WD_STEP_HI - `SBCSE_WD_OFFSET_HI; // RULE3
    end
  end

endmodule : sbcse_period
`default_nettype wire

// >>> dv/sbcse_encoder_monitor.sv
// port checks of the spi status encoder
// assumes a bind into sbcse_encoder, one clock domain
`timescale 1ns/10ps
`default_nettype none
module sbcse_encoder_monitor (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic LEAVE_SLEEP_FS_I,
  input wire logic RESTART_EVENT_I,
  input wire logic [1:0] RESTART_CAUSE_I,
  input wire logic LIMP_EVENT_I,
  input wire logic [2:0] LIMP_CAUSE_I,
  input wire logic [1:0] RESET_THRESHOLD_O,
  input wire logic [4:0] WD_FIELD_O,
  input wire logic [10:0] WD_PERIOD_MS_O,
  input wire logic WD_SERVICE_O,
  input wire logic MODE_REQ_VALID_O,
  input wire logic [2:0] MODE_REQ_O,
  input wire logic [9:0] MAIN_REG_O,
  input wire logic [1:0] RESTART_CAUSE_O,
  input wire logic [2:0] LIMP_CAUSE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  property p_thr; RESET_THRESHOLD_O != 2'h0; endproperty
  a_thr: assert property (p_thr) else $error("threshold code zero");
  property p_per; WD_PERIOD_MS_O == (WD_FIELD_O[4] ? 11'(WD_FIELD_O) * 11'h030 - 11'h1D0
    : (11'(WD_FIELD_O) + 11'h001) * 11'h010); endproperty
  a_per: assert property (p_per) else $error("watchdog period decode");
  // a frame only counts once chip select was seen low then high
  property p_svc; WD_SERVICE_O |-> $past(CHIP_SELECT_N_I) && !$past(CHIP_SELECT_N_I, 2); endproperty
  a_svc: assert property (p_svc) else $error("service without frame end");
  property p_req; MODE_REQ_VALID_O |-> WD_SERVICE_O && MODE_REQ_O != 3'h7; endproperty
  a_req: assert property (p_req) else $error("mode request mismatch");
  property p_main; $changed(MAIN_REG_O) |-> MODE_REQ_VALID_O; endproperty
  a_main: assert property (p_main) else $error("main register changed alone");
  property p_rld; RESTART_EVENT_I |=> RESTART_CAUSE_O == $past(RESTART_CAUSE_I); endproperty
  a_rld: assert property (p_rld) else $error("restart cause not loaded");
  property p_lld; LIMP_EVENT_I |=> LIMP_CAUSE_O == $past(LIMP_CAUSE_I); endproperty
  a_lld: assert property (p_lld) else $error("limp cause not loaded");
  property p_lv; LEAVE_SLEEP_FS_I && !RESTART_EVENT_I |=> RESTART_CAUSE_O == 2'h0; endproperty
  a_lv: assert property (p_lv) else $error("restart cause kept on leave");
  c_ro: cover property (WD_SERVICE_O && !MODE_REQ_VALID_O);
  c_wr: cover property (MODE_REQ_VALID_O);
  c_lv: cover property (LEAVE_SLEEP_FS_I);
endmodule : sbcse_encoder_monitor
bind sbcse_encoder sbcse_encoder_monitor u_mon (.CLK_I, .RST_I, .CHIP_SELECT_N_I,
  .LEAVE_SLEEP_FS_I, .RESTART_EVENT_I, .RESTART_CAUSE_I, .LIMP_EVENT_I, .LIMP_CAUSE_I,
  .RESET_THRESHOLD_O, .WD_FIELD_O, .WD_PERIOD_MS_O, .WD_SERVICE_O, .MODE_REQ_VALID_O,
  .MODE_REQ_O, .MAIN_REG_O, .RESTART_CAUSE_O, .LIMP_CAUSE_O);
`default_nettype wire

// >>> dv/sbcse_spi_master.sv
// controller side of the spi link, one 16-bit frame per call
// assumes the clock of the encoder; sclk idles low, sdi pulled down
`timescale 1ns/10ps
`default_nettype none
module sbcse_spi_master (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // every frame also serves the watchdog, read-only included
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_i) cs_n_o <= 1'b0;
    tick(2);
    for (int i = 0; i < 16; i++) begin
      sdi_o <= tx[i];
      tick(2);
      sclk_o <= 1'b1;
      // sampled mid-cycle: sdo only moves after a fall
      @(negedge clk_i) rx[i] = sdo_i;
      tick(2);
      sclk_o <= 1'b0;
    end
    tick(2);
    cs_n_o <= 1'b1;
    sdi_o <= 1'b0;
    tick(3);
  endtask : xfer
endmodule : sbcse_spi_master
`default_nettype wire

// >>> dv/sbcse_tb.sv
// self-checking bench of the spi status encoder
// assumes the master model and the bound monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, sdi, serial_data_out;
  logic [3:0] ev = 4'h0;
  logic [1:0] rc = 2'h0;
  logic [2:0] lc = 3'h0;
  logic [2:0] hw = 3'h0;
  logic [9:0] wake = 10'h000;
  sbcse_pkg::sbcse_entry_type from = sbcse_pkg::SBCSE_FROM_INIT;
  logic [1:0] thr, rco;
  logic [2:0] lco;
  logic [10:0] per;
  logic [15:0] rx;
  logic dev;
  logic [9:0] mreg;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  sbcse_spi_master u_mst (.clk_i(clk), .sdo_i(serial_data_out), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  sbcse_encoder u_dut (.CLK_I(clk), .RST_I(rst), .CHIP_SELECT_N_I(cs_n), .SCLK_I(sclk),
    .SDI_I(sdi), .SERIAL_DATA_OUT_O(serial_data_out), .SERIAL_DATA_OUT_OE_O(), .CUR_MODE_I(3'h1),
    .NORMAL_ENTRY_I(ev[3]), .ENTRY_FROM_I(from), .LEAVE_SLEEP_FS_I(ev[2]),
    .RESTART_EVENT_I(ev[1]), .RESTART_CAUSE_I(rc), .LIMP_EVENT_I(ev[0]), .LIMP_CAUSE_I(lc),
    .WAKE_SET_I(wake), .HW_CONFIG_I(hw), .RESET_THRESHOLD_O(thr), .WD_FIELD_O(),
    .WD_PERIOD_MS_O(per), .SW_DEV_MODE_O(dev), .WD_SERVICE_O(), .MODE_REQ_VALID_O(),
    .MODE_REQ_O(), .MAIN_REG_O(mreg), .COMM_REG_O(), .WDOG_REG_O(),
    .RESTART_CAUSE_O(rco), .LIMP_CAUSE_O(lco));
  task automatic conclude;
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic fire(input logic [3:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 4'h0;
    tick2();
  endtask : fire
  task automatic tick2();
    repeat (2) @(posedge clk);
  endtask : tick2
  task automatic fr(input logic [2:0] mode, input logic [2:0] sel, input logic [9:0] data);
    u_mst.xfer({data, sel, mode}, rx);
  endtask : fr
  task automatic t_diag;
    @(posedge clk) hw <= 3'h2;
    rc <= 2'h2;
    lc <= 3'h5;
    from <= sbcse_pkg::SBCSE_FROM_FAILSAFE;
    fire(4'h3);
    fire(4'h8);
    fr(3'h1, 3'h5, 10'h001);
    chk("first", {10'h056, 3'h7, 3'h4}, rx);
    chk("kept", 16'h0016, {11'h000, lco, rco});
    fr(3'h7, 3'h7, 10'h000);
    chk("ro data", 16'h0056, 16'(rx[15:6]));
    chk("ro clr", 16'h0014, {11'h000, lco, rco});
    fr(3'h1, 3'h4, 10'h115);
    chk("limp off", 16'h0000, 16'(lco));
  endtask : t_diag
  task automatic t_leave;
    for (int c = 1; c < 4; c++) begin
      @(posedge clk) rc <= 2'(c);
      fire(4'h2);
      chk("cause", 16'(c), 16'(rco));
      fire(4'h4);
      chk("leave", 16'h0000, 16'(rco));
    end
  endtask : t_leave
  task automatic t_thr;
    logic [1:0] code [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
    logic [1:0] want [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
    for (int i = 0; i < 4; i++) begin
      fr(3'h1, 3'h4, {8'h45, code[i]});
      chk("thr", 16'(want[i]), 16'(thr));
    end
  endtask : t_thr
  task automatic t_wd;
    logic [4:0] n [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
    logic [10:0] ms [4] = '{11'h010, 11'h100, 11'h130, 11'h400};
    for (int i = 0; i < 4; i++) begin
      fr(3'h1, 3'h6, {5'h0F, n[i]});
      chk("period", 16'(ms[i]), 16'(per));
      // select 000 is never written, so it only polls
      fr(3'h1, 3'h0, 10'h000);
      chk("reply", {5'h0F, n[i], 3'h6, 3'h1}, rx);
    end
  endtask : t_wd
  task automatic t_first(input sbcse_pkg::sbcse_entry_type f, input logic [15:0] exp);
    @(posedge clk) from <= f;
    fire(4'h8);
    fr(3'h1, 3'h0, 10'h000);
    chk("first", exp, rx);
  endtask : t_first
  // read-only: same-frame data, clears only what it selects, writes nothing
  task automatic t_ro;
    fr(3'h7, 3'h3, 10'h000);
    chk("ro wake", 16'h0004, 16'(rx[15:6]));
    fr(3'h7, 3'h3, 10'h000);
    chk("ro wake clr", 16'h0000, 16'(rx[15:6]));
    fr(3'h7, 3'h4, 10'h3FF);
    chk("ro main", 16'h0115, 16'(rx[15:6]));
    chk("ro no write", 16'h0115, 16'(mreg));
    chk("ro thr", 16'h0001, 16'(thr));
    @(posedge clk) hw <= 3'h4;
    tick2();
    chk("dev mode", 16'h0001, 16'(dev));
    fr(3'h7, 3'h7, 10'h000);
    chk("ro hw", 16'h0080, 16'(rx[15:6]));
  endtask : t_ro
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick2();
    chk("thr rst", 16'h0001, 16'(thr));
    chk("per rst", 16'h0100, 16'(per));
    t_diag;
    t_leave;
    t_thr;
    t_wd;
    @(posedge clk) wake <= 10'h004;
    @(posedge clk) wake <= 10'h000;
    t_first(sbcse_pkg::SBCSE_FROM_SLEEP, {10'h004, 3'h3, 3'h2});
    t_first(sbcse_pkg::SBCSE_FROM_RESTART_FAIL, {10'h040, 3'h7, 3'h3});
    t_first(sbcse_pkg::SBCSE_FROM_RESTART_REQ, {10'h115, 3'h4, 3'h3});
    t_first(sbcse_pkg::SBCSE_FROM_INIT, {10'h115, 3'h4, 3'h0});
    t_ro;
    conclude;
  end
  // about 25 frames of 72 cycles each; ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      conclude;
    end
  end
endmodule : tb
`default_nettype wire
